// ---- hw/vof_pkg.sv ----
// Constants, field layout and types of the video output formatter.
// Assumes a single 25 MHz system clock and a parameter RAM write port.
package vof_pkg;
  // Parameter RAM addresses and flop array indices.
  localparam logic [8:0] A_PEAK1 = 9'h126;
  localparam logic [8:0] A_ADJA1 = 9'h127;
  localparam logic [8:0] A_ADJB1 = 9'h128;
  localparam logic [8:0] A_PEAK2 = 9'h130;
  localparam logic [8:0] A_ADJA2 = 9'h131;
  localparam logic [8:0] A_ADJB2 = 9'h132;
  localparam logic [8:0] A_FMT = 9'h150;
  localparam logic [8:0] A_MUX = 9'h154;
  localparam logic [8:0] A_STAT = 9'h15f;
  localparam int NREG = 8;
  localparam logic [2:0] I_PEAK1 = 3'h0;
  localparam logic [2:0] I_ADJA1 = 3'h1;
  localparam logic [2:0] I_ADJB1 = 3'h2;
  localparam logic [2:0] I_PEAK2 = 3'h3;
  localparam logic [2:0] I_ADJA2 = 3'h4;
  localparam logic [2:0] I_ADJB2 = 3'h5;
  localparam logic [2:0] I_FMT = 3'h6;
  localparam logic [2:0] I_MUX = 3'h7;
  // Reset values: unity gain, zero brightness, everything else clear.
  localparam logic [11:0] RST_ADJA = 12'h020;
  localparam logic [11:0] RST_ADJB = 12'h07f;
  localparam logic [11:0] RST_OTHER = 12'h000;
  // Field positions.
  localparam int FMT_VBIEN = 2;
  localparam int FMT_RANGE = 3;
  localparam int FMT_SHUF = 6;
  localparam int FMT_HSUP = 9;
  localparam int FMT_EAVUPD = 10;
  localparam int FMT_TASK = 11;
  localparam int MUX_DBL = 9;
  localparam int MUX_HALF = 10;
  localparam int ADJ_CLAMP = 8;
  localparam int PEAK_SWAP = 8;
  localparam logic [1:0] FMT_656 = 2'h1;
  // Code values.
  localparam logic [7:0] CODE_FF = 8'hff;
  localparam logic [7:0] CODE_00 = 8'h00;
  localparam logic [7:0] FILL_Y = 8'h10;
  localparam logic [7:0] FILL_C = 8'h80;
  localparam logic [7:0] LIM_LO = 8'h01;
  localparam logic [7:0] LIM_HI = 8'hfe;
  localparam logic [7:0] CLAMP_LO16 = 8'h10;
  localparam logic [7:0] CLAMP_LO32 = 8'h20;
  localparam logic [12:0] OFFS_BIAS4 = 13'h01fc;
  localparam logic [9:0] Y_MAX10 = 10'h3fb;
  localparam logic [1:0] ROUND_HALF = 2'h2;
  localparam logic [2:0] KEEP_LINES = 3'h4;
  localparam logic [2:0] DID_TAG = 3'h2;
  localparam int DLY = 8;
  // Types.
  typedef enum logic [1:0] {
    RQ_ROUND = 2'h0, RQ_TRUNC = 2'h1, RQ_ED1 = 2'h2, RQ_ED2 = 2'h3
  } vof_rq_t;
  typedef enum logic [1:0] {
    K_FILL = 2'h0, K_DATA = 2'h1, K_HDR = 2'h3, K_ANC = 2'h2
  } vof_kind_t;
  typedef struct packed {
    logic act;
    logic hr;
    logic vr;
    logic [7:0] y;
    logic [7:0] c;
  } vof_pix_t;
  typedef struct packed {
    logic vbl;
    logic vbi;
    logic fld;
    logic win2;
  } vof_line_t;
endpackage

// ---- hw/vof_luma_if.sv ----
// Signals between the formatter and its luma adjust unit.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface vof_luma_if;
  logic [7:0] y_in;
  logic [5:0] gain;
  logic [7:0] offs;
  logic clamp32;
  vof_pkg::vof_rq_t method;
  logic step;
  logic [7:0] y_out;
  modport ctl (output y_in, gain, offs, clamp32, method, step,
    input y_out);
  modport unit (input y_in, gain, offs, clamp32, method, step,
    output y_out);
endinterface

// ---- hw/vof_luma_adj.sv ----
// Luma contrast, brightness, clamp and requantisation to 8 bits.
// Assumes step pulses once per active pixel on the system clock.
`timescale 1ns/1ps
module vof_luma_adj
  import vof_pkg::*;
(
  // Clock and reset.
  input logic mclk,
  input logic rst,
  // Adjust request and result.
  vof_luma_if.unit lif
);
  logic [13:0] prod;
  logic signed [12:0] sum;
  logic [9:0] v10;
  logic [9:0] lo10;
  logic [10:0] acc;
  logic [1:0] add;
  logic [1:0] err;

  // Gain carries five fraction bits; three are dropped so the sum keeps
  // two bits below the output LSB, a 10-bit intermediate.
  always_comb begin
    prod = lif.gain * lif.y_in;
    sum = $signed({2'b00, prod[13:3]}) +
      $signed({3'b000, lif.offs, 2'b00}) - $signed(OFFS_BIAS4);
    lo10 = {(lif.clamp32 ? CLAMP_LO32 : CLAMP_LO16), 2'b00};
    if (sum < $signed({3'b000, lo10})) begin
      v10 = lo10;
    end else if (sum > $signed({3'b000, Y_MAX10})) begin
      v10 = Y_MAX10;
    end else begin
      v10 = sum[9:0];
    end
    case (lif.method)
      RQ_ROUND: add = ROUND_HALF;
      RQ_TRUNC: add = 2'h0;
      RQ_ED1: add = {err[0], 1'b0};
      default: add = err;
    endcase
    acc = {1'b0, v10} + {9'h000, add};
  end

  // The top code is reserved, so a carry into it is pulled back.
  assign lif.y_out = (acc[9:2] == CODE_FF) ? LIM_HI : acc[9:2];

  // Diffused error only moves on active pixels, so it holds across blanking.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      err <= 2'h0;
    end else if (lif.step) begin
      err <= (lif.method == RQ_ED1) ? {1'b0, acc[1]} : acc[1:0];
    end
  end

  chk_luma_floor: assert property (@(posedge mclk) disable iff (rst)
    lif.y_out >= lo10[9:2] && lif.y_out != CODE_FF)
    else $error("luma left the clamp range");
endmodule

// ---- hw/vof_top.sv ----
// Video output formatter: luma adjust, chroma swap, 16-bit or 8-bit
// stream with embedded headers and ancillary VBI headers.
// Assumes pixel inputs come from logic on mclk and pix_clk is slower
// than half of mclk; registers are written through the parameter port.
`timescale 1ns/1ps
module vof_top
  import vof_pkg::*;
(
  // Clock and reset.
  input logic mclk,
  input logic rst,
  // Parameter RAM port.
  input logic pram_we,
  input logic [8:0] pram_addr,
  input logic [11:0] pram_wdata,
  output logic [11:0] pram_rdata,
  // Pixel clock, asynchronous to mclk.
  input logic pix_clk,
  // Pixel stream and line information from the component stage.
  input logic [7:0] in_y,
  input logic [7:0] in_c,
  input logic in_active,
  input logic in_href,
  input logic in_vref,
  input logic in_field,
  input logic in_vblank,
  input logic in_vbi,
  input logic in_win2,
  input logic [2:0] anc_type,
  input logic [11:0] anc_count,
  // Video ports and reference outputs.
  output logic [7:0] port_a,
  output logic [7:0] port_b,
  output logic href_out,
  output logic vref_out,
  output logic field_out,
  output logic active_video_qualifier
);
  logic [11:0] prm [NREG];
  logic [3:0] wdec;
  logic [3:0] rdec;
  logic [11:0] fmt;
  logic [11:0] mux;
  logic m656;
  logic dbl;
  logic half;
  logic shuf;
  logic pc_s1;
  logic pc_s2;
  logic pc_s3;
  logic rise;
  logic fall;
  vof_pix_t dl [DLY];
  vof_pix_t o;
  logic [5:0] sav_k;
  logic eav_k0;
  logic eav_k1;
  vof_line_t ln_cur;
  vof_line_t ln_prev;
  vof_line_t use_ln;
  logic [2:0] vbcnt;
  logic line_en;
  logic vbi_ln;
  logic anc_ln;
  logic drop;
  logic [2:0] flg;
  logic [2:0] hf;
  logic [2:0] hflag;
  logic ph;
  logic [11:0] peak;
  logic [11:0] adja;
  logic [11:0] adjb;
  logic [7:0] cc;
  logic [7:0] dat_c;
  logic [7:0] dat_y;
  logic [7:0] next_c;
  logic [7:0] next_y;
  vof_kind_t next_kind;
  logic [7:0] pc_r;
  logic [7:0] py_r;
  vof_kind_t kind_r;
  logic len_r;
  logic vbi_r;
  logic act_r;
  logic p656_r;
  logic hr_r;
  logic vr_r;
  logic fld_r;
  logic hph;
  vof_luma_if lif ();

  // One address decoder serves both the write and the read path.
  function automatic logic [3:0] reg_dec(input logic [8:0] a);
    case (a)
      A_PEAK1: reg_dec = {1'b1, I_PEAK1};
      A_ADJA1: reg_dec = {1'b1, I_ADJA1};
      A_ADJB1: reg_dec = {1'b1, I_ADJB1};
      A_PEAK2: reg_dec = {1'b1, I_PEAK2};
      A_ADJA2: reg_dec = {1'b1, I_ADJA2};
      A_ADJB2: reg_dec = {1'b1, I_ADJB2};
      A_FMT: reg_dec = {1'b1, I_FMT};
      A_MUX: reg_dec = {1'b1, I_MUX};
      default: reg_dec = 4'h0;
    endcase
  endfunction

  // Values 0 and 255 mark headers, so video is held inside 1..254.
  function automatic logic [7:0] lim(input logic [7:0] d);
    if (d == CODE_00) begin
      lim = LIM_LO;
    end else if (d == CODE_FF) begin
      lim = LIM_HI;
    end else begin
      lim = d;
    end
  endfunction

  // VBI samples: limited, or seven bits with an odd parity LSB.
  function automatic logic [7:0] rng(input logic [7:0] d,
    input logic par);
    rng = par ? {d[7:1], ~(^d[7:1])} : lim(d);
  endfunction

  // Fourth header word: flags and their protection bits.
  function automatic logic [7:0] hdr_word(input logic t, input logic f,
    input logic v, input logic h);
    hdr_word = {t, f, v, h, h ^ v ^ ~t, h ^ f ^ ~t, v ^ f ^ ~t,
      h ^ v ^ ~f};
  endfunction

  // Ancillary header word: inverted parity, even parity, six payload bits.
  function automatic logic [7:0] anc_word(input logic [5:0] d);
    anc_word = {~(^d), ^d, d};
  endfunction

  assign wdec = reg_dec(pram_addr);
  assign rdec = reg_dec(pram_addr);
  assign fmt = prm[I_FMT];
  assign mux = prm[I_MUX];
  assign m656 = fmt[1:0] == FMT_656;
  assign dbl = mux[MUX_DBL];
  assign half = mux[MUX_HALF];
  assign shuf = fmt[FMT_SHUF];

  // Parameter writes land in the flop array by index.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NREG; i++) begin
        prm[i] <= RST_OTHER;
      end
      prm[I_ADJA1] <= RST_ADJA;
      prm[I_ADJA2] <= RST_ADJA;
      prm[I_ADJB1] <= RST_ADJB;
      prm[I_ADJB2] <= RST_ADJB;
    end else if (pram_we && wdec[3]) begin
      prm[wdec[2:0]] <= pram_wdata;
    end
  end

  // Reads follow the address one cycle later; unmapped reads give zero.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pram_rdata <= 12'h000;
    end else if (rdec[3]) begin
      pram_rdata <= prm[rdec[2:0]];
    end else if (pram_addr == A_STAT) begin
      pram_rdata <= {7'h00, hf, line_en, act_r};
    end else begin
      pram_rdata <= 12'h000;
    end
  end

  // Pixel clock synchroniser; only the second and third stages are read.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {pc_s3, pc_s2, pc_s1} <= 3'h0;
    end else begin
      {pc_s3, pc_s2, pc_s1} <= {pc_s2, pc_s1, pix_clk};
    end
  end
  assign rise = pc_s2 & ~pc_s3;
  assign fall = ~pc_s2 & pc_s3;

  // Eight-pixel delay line: headers are written over the blanking that
  // precedes active data, which costs latency but needs no FIFO.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DLY; i++) begin
        dl[i] <= '0;
      end
    end else if (rise) begin
      dl[0] <= {in_active, in_href, in_vref, in_y, in_c};
      for (int i = 1; i < DLY; i++) begin
        dl[i] <= dl[i-1];
      end
    end
  end
  assign o = dl[6];

  // A rising active edge at stage n marks header slot n of the output.
  for (genvar g = 0; g < 6; g++) begin : g_slot
    assign sav_k[g] = dl[g].act & ~dl[g+1].act;
  end
  assign eav_k0 = ~o.act & dl[7].act;

  // Line information is caught as a new active window starts.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ln_cur <= '0;
      ln_prev <= '0;
      vbcnt <= 3'h0;
    end else if (rise && in_active && !dl[0].act) begin
      ln_prev <= ln_cur;
      ln_cur <= {in_vblank, in_vbi, in_field, in_win2};
      if (!in_vblank) begin
        vbcnt <= 3'h0;
      end else if (vbcnt != KEEP_LINES) begin
        vbcnt <= vbcnt + 3'h1;
      end
    end
  end

  // With EAV updates the windows run one line late.
  assign use_ln = fmt[FMT_EAVUPD] ? ln_prev : ln_cur;
  assign line_en = ~use_ln.vbl | (use_ln.vbi & fmt[FMT_VBIEN]);
  assign vbi_ln = use_ln.vbi & line_en;
  assign anc_ln = vbi_ln & m656;
  // The first lines of field blanking keep headers for vertical sync.
  assign drop = fmt[FMT_HSUP] & ~line_en & (vbcnt == KEEP_LINES);
  assign flg = {~(fmt[FMT_TASK] & use_ln.vbi), use_ln.fld,
    use_ln.vbl & ~line_en};
  assign hflag = fmt[FMT_EAVUPD] ? hf : flg;

  // Header flags, chroma phase and the second EAV slot.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hf <= 3'h0;
      ph <= 1'b0;
      eav_k1 <= 1'b0;
    end else if (rise) begin
      if (eav_k0) begin
        hf <= flg;
      end
      ph <= o.act & ~ph;
      eav_k1 <= eav_k0;
    end
  end

  // Window registers and the Cb/Cr swap taken from a neighbour sample.
  assign peak = use_ln.win2 ? prm[I_PEAK2] : prm[I_PEAK1];
  assign adja = use_ln.win2 ? prm[I_ADJA2] : prm[I_ADJA1];
  assign adjb = use_ln.win2 ? prm[I_ADJB2] : prm[I_ADJB1];
  assign cc = !peak[PEAK_SWAP] ? o.c : (!ph ? dl[5].c : dl[7].c);

  // Luma adjust unit fed from the output stage of the delay line.
  assign lif.y_in = o.y;
  assign lif.gain = adja[5:0];
  assign lif.offs = adjb[7:0];
  assign lif.clamp32 = adja[ADJ_CLAMP];
  assign lif.method = vof_rq_t'(adja[10:9]);
  assign lif.step = rise & o.act;
  vof_luma_adj u_luma (
    .mclk(mclk),
    .rst(rst),
    .lif(lif.unit)
  );

  assign dat_y = vbi_ln ? rng(o.y, fmt[FMT_RANGE]) : lif.y_out;
  assign dat_c = vbi_ln ? rng(cc, fmt[FMT_RANGE]) : lim(cc);

  // Next Y/C pair: data, blanking fill, timing header or ancillary words.
  always_comb begin
    next_c = FILL_C;
    next_y = FILL_Y;
    next_kind = K_FILL;
    if (o.act && line_en) begin
      next_c = dat_c;
      next_y = dat_y;
      next_kind = K_DATA;
    end
    if (m656 && !drop) begin
      if (eav_k0 || (anc_ln ? sav_k[0] : sav_k[4])) begin
        next_c = CODE_FF;
        next_y = CODE_00;
        next_kind = K_HDR;
      end else if (eav_k1 || (anc_ln ? sav_k[1] : sav_k[5])) begin
        next_c = CODE_00;
        next_y = hdr_word(hflag[2], hflag[1], hflag[0], eav_k1);
        next_kind = K_HDR;
      end else if (anc_ln && sav_k[3]) begin
        next_c = CODE_00;
        next_y = CODE_FF;
        next_kind = K_ANC;
      end else if (anc_ln && sav_k[4]) begin
        next_c = CODE_FF;
        next_y = anc_word({DID_TAG, anc_type});
        next_kind = K_ANC;
      end else if (anc_ln && sav_k[5]) begin
        next_c = anc_word(anc_count[11:6]);
        next_y = anc_word(anc_count[5:0]);
        next_kind = K_ANC;
      end
    end
  end

  // Pair registers, taken once per pixel clock.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_r <= FILL_C;
      py_r <= FILL_Y;
      kind_r <= K_FILL;
      {len_r, vbi_r, act_r, p656_r, hph} <= 5'h00;
      {hr_r, vr_r, fld_r} <= 3'h0;
    end else if (rise) begin
      pc_r <= next_c;
      py_r <= next_y;
      kind_r <= next_kind;
      len_r <= line_en;
      vbi_r <= use_ln.vbi;
      act_r <= o.act & line_en;
      p656_r <= m656;
      hph <= ~hph;
      {hr_r, vr_r, fld_r} <= {o.hr, o.vr, use_ln.fld};
    end
  end

  // Port drive: with the shuffler off, the double clock sends chroma on the falling pixel edge
  // and luma on the next rising one; port B then is a free output.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_a <= 8'h00;
      port_b <= 8'h00;
    end else if (dbl) begin
      if (fall) begin
        port_a <= shuf ? py_r : pc_r;
      end else if (rise) begin
        port_a <= shuf ? pc_r : py_r;
      end
      port_b <= mux[7:0];
    end else if (fall && (!half || hph)) begin
      port_a <= shuf ? pc_r : py_r;
      port_b <= shuf ? py_r : pc_r;
    end
  end

  // References leave together with the data they describe.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {href_out, vref_out, field_out} <= 3'h0;
      active_video_qualifier <= 1'b0;
    end else if (fall) begin
      {href_out, vref_out, field_out} <= {hr_r, vr_r, fld_r};
      active_video_qualifier <= act_r;
    end
  end

  chk_no_reserved_codes: assert property (@(posedge mclk)
    disable iff (rst) (p656_r && kind_r == K_DATA) |->
    (pc_r != CODE_FF && pc_r != CODE_00 && py_r != CODE_FF &&
    py_r != CODE_00))
    else $error("reserved code in video data");

  chk_eav_after_data: assert property (@(posedge mclk)
    disable iff (rst) (rise && m656 && eav_k0 && !drop) |=>
    (pc_r == CODE_FF && py_r == CODE_00 && kind_r == K_HDR))
    else $error("end header missing after active data");

  chk_sav_flag_word: assert property (@(posedge mclk)
    disable iff (rst) (rise && m656 && sav_k[5] && !anc_ln && !drop) |=>
    (pc_r == CODE_00 && !py_r[4] && py_r[7] == $past(hflag[2])))
    else $error("start header word wrong before active data");

  chk_hdr_protect: assert property (@(posedge mclk)
    disable iff (rst) (kind_r == K_HDR && pc_r == CODE_00) |->
    (py_r[3] == (py_r[4] ^ py_r[5] ^ ~py_r[7]) &&
    py_r[2] == (py_r[4] ^ py_r[6] ^ ~py_r[7]) &&
    py_r[1] == (py_r[5] ^ py_r[6] ^ ~py_r[7]) &&
    py_r[0] == (py_r[4] ^ py_r[5] ^ ~py_r[6])))
    else $error("header protection bits wrong");

  chk_vflag_enabled: assert property (@(posedge mclk)
    disable iff (rst) (kind_r == K_HDR && pc_r == CODE_00 && len_r &&
    !fmt[FMT_EAVUPD]) |-> !py_r[5])
    else $error("vertical flag set on enabled line");

  chk_task_vbi: assert property (@(posedge mclk)
    disable iff (rst) (kind_r == K_HDR && pc_r == CODE_00 && vbi_r &&
    fmt[FMT_TASK] && !fmt[FMT_EAVUPD]) |-> !py_r[7])
    else $error("task flag set inside VBI window");

  chk_anc_gap: assert property (@(posedge mclk)
    disable iff (rst) (rise && m656 && anc_ln && sav_k[3]) |->
    (kind_r == K_FILL))
    else $error("ancillary packet right after header");

  chk_blank_no_active_video_qualifier: assert property (@(posedge mclk)
    disable iff (rst) (rise && !line_en) |=> !act_r ##1 !act_r)
    else $error("qualifier raised on blanked line");

  chk_dbl_chroma_first: assert property (@(posedge mclk)
    disable iff (rst) (fall && dbl && !shuf) |=> (port_a == $past(pc_r)))
    else $error("double clock did not send chroma on falling edge");
endmodule

// ---- testbench/vof_sink.sv ----
// Capture model of the receiver downstream of the formatter.
// Assumes pix_clk edges sit clear of the formatter's output updates.
`timescale 1ns/1ps
module vof_sink (
  // Link clock.
  input wire logic pix_clk,
  // Video ports from the formatter.
  input wire logic [7:0] port_a,
  input wire logic [7:0] port_b,
  input wire logic active_video_qualifier
);
  logic [7:0] qa[$];
  logic [15:0] qw[$];
  int nqual;
  // Each edge takes what the opposite edge launched; any line length
  // and any blanking width is accepted.
  always @(pix_clk) begin
    #20;
    qa.push_back(port_a);
    if (active_video_qualifier === 1'b1) begin
      nqual++;
      if (pix_clk) qw.push_back({port_a, port_b});
    end
  end
endmodule

// ---- testbench/vof_top_test.sv ----
// Self-checking bench of the video output formatter.
// Assumes the formatter and the capture model are compiled first.
`timescale 1ns/1ps
module vof_top_test import vof_pkg::*;;
  logic mclk, rst, pram_we, pix_clk, in_active, in_href, in_vref;
  logic in_field, in_vblank, avq;
  logic href_out, vref_out, field_out, vbi;
  logic [1:0] vf;
  logic [7:0] pb;
  logic [8:0] pram_addr;
  logic [11:0] pram_wdata, pram_rdata, w, d;
  logic [7:0] in_y, in_c, port_a, port_b;
  logic [7:0] ey[$], ec[$];
  int mismatches, check_count, cycles, k, nref;
  integer seed = 32'he3e77cb3;
  logic [8:0] addrs[9] = '{A_PEAK1, A_ADJA1, A_ADJB1, A_PEAK2, A_ADJA2,
    A_ADJB2, A_FMT, A_MUX, 9'h140};
  logic [11:0] rstv[9] = '{12'h000, RST_ADJA, RST_ADJB, 12'h000,
    RST_ADJA, RST_ADJB, 12'h000, 12'h000, 12'h000};
  logic [11:0] ca[2] = '{RST_ADJA, 12'h330};
  logic [11:0] cb[2] = '{RST_ADJB, 12'h089};

  vof_top DUT (.mclk(mclk), .rst(rst), .pram_we(pram_we),
    .pram_addr(pram_addr), .pram_wdata(pram_wdata),
    .pram_rdata(pram_rdata), .pix_clk(pix_clk), .in_y(in_y),
    .in_c(in_c), .in_active(in_active), .in_href(in_href),
    .in_vref(in_vref), .in_field(in_field), .in_vblank(in_vblank),
    .in_vbi(vbi), .in_win2(1'b0), .anc_type(3'h5),
    .anc_count(12'h11d), .port_a(port_a), .port_b(port_b),
    .href_out(href_out), .vref_out(vref_out), .field_out(field_out),
    .active_video_qualifier(avq));
  vof_sink SINK (.pix_clk(pix_clk), .port_a(port_a), .port_b(port_b),
    .active_video_qualifier(avq));

  // System clock.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Link clock, offset so its edges never meet a sampling edge.
  initial begin
    pix_clk = 1'b0;
    #13;
    forever #160 pix_clk = ~pix_clk;
  end
  // References and port B are watched where the sink looks at the data.
  always @(posedge pix_clk) begin
    #20;
    nref += (href_out === 1'b1) ? 1 : 0;
    vf = {vref_out, field_out};
    pb = port_b;
  end
  // A hang is cut short after far more cycles than the run needs.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      finish_test;
    end
  end

  task automatic finish_test;
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmpw(input logic [11:0] got, exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: word %h, want %h", $time, got, exp);
    end
  endtask
  task automatic cmpb(input logic [7:0] got, exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [11:0] v);
    @(posedge mclk);
    #1;
    pram_addr = a;
    pram_wdata = v;
    pram_we = 1'b1;
    @(posedge mclk);
    #1;
    pram_we = 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, output logic [11:0] v);
    @(posedge mclk);
    #1;
    pram_addr = a;
    @(posedge mclk);
    #1;
    v = pram_rdata;
  endtask
  // Inputs change just after the mclk edge that follows a pixel fall,
  // so they are steady when the next rise is detected.
  task automatic px(input logic [7:0] y, c, input logic act);
    @(negedge pix_clk);
    @(posedge mclk);
    #1;
    in_y = y;
    in_c = c;
    in_active = act;
    in_href = act;
  endtask
  // Reference luma: gain in 32nds, offset code less 127, floor, clamp.
  function automatic logic [7:0] lum(input logic [7:0] y,
      input logic [11:0] a, b);
    int v;
    v = int'(y) * int'(a[5:0]) / 32 + int'(b[7:0]) - 127;
    if (v < (a[8] ? 32 : 16)) v = a[8] ? 32 : 16;
    if (v > 254) v = 254;
    return v[7:0];
  endfunction
  function automatic logic [7:0] xy(input logic t, f, v, h);
    return {t, f, v, h, h ^ v ^ ~t, h ^ f ^ ~t, v ^ f ^ ~t, h ^ v ^ ~f};
  endfunction
  // One line: blanking, eight samples with both extremes, blanking.
  task automatic line(input logic [11:0] a, b, input logic sw);
    logic [7:0] y[8], c[8];
    for (int j = 0; j < 8; j++) begin
      y[j] = (j == 0) ? 8'h00 : (j == 1) ? 8'hff : 8'($random(seed));
      c[j] = 8'h01 + 8'($unsigned($random(seed)) % 254);
    end
    SINK.qa.delete();
    SINK.qw.delete();
    SINK.nqual = 0;
    nref = 0;
    ey.delete();
    ec.delete();
    // VBI samples bypass the luma adjust and are only limited.
    for (int j = 0; j < 8; j++) begin
      ey.push_back(vbi ? ((y[j] == 8'h00) ? 8'h01 :
        (y[j] == 8'hff) ? 8'hfe : y[j]) : lum(y[j], a, b));
      ec.push_back(c[sw ? j ^ 1 : j]);
    end
    for (int j = 0; j < 12; j++) px(8'h10, 8'h80, 1'b0);
    for (int j = 0; j < 8; j++) px(y[j], c[j], 1'b1);
    for (int j = 0; j < 14; j++) px(8'h10, 8'h80, 1'b0);
  endtask
  // With the shuffler on, chroma leaves on port A and luma on port B.
  task automatic chk16(input logic sh);
    logic [15:0] w16;
    cmpw(12'(SINK.qw.size()), 12'h008);
    cmpw(12'(nref), 12'h008);
    for (int j = 0; j < 8 && j < SINK.qw.size(); j++) begin
      w16 = sh ? {SINK.qw[j][7:0], SINK.qw[j][15:8]} : SINK.qw[j];
      cmpb(w16[15:8], ey[j]);
      cmpb(w16[7:0], ec[j]);
    end
  endtask
  // The stream is lined up on its first header; a missing one fails.
  // An ancillary line adds fill, preamble, type 5 and count 285 words.
  task automatic chk656(input logic t, f, v, a);
    logic [7:0] q[$];
    int s;
    s = 0;
    q = '{8'h80, 8'h10, 8'hff, 8'h00, 8'h00, xy(t, f, v, 1'b0)};
    if (a) begin
      q = {q, 8'h80, 8'h10, 8'h00, 8'hff, 8'hff};
      q = {q, 8'h55, 8'h44, 8'h9d};
    end
    if (!v) begin
      for (int j = 0; j < 8; j++) q = {q, ec[j], ey[j]};
      q = {q, 8'hff, 8'h00, 8'h00, xy(t, f, v, 1'b1), 8'h80, 8'h10};
    end
    for (int j = SINK.qa.size() - 4; j >= 2; j--) begin
      if (SINK.qa[j] === 8'hff && SINK.qa[j + 1] === 8'h00) s = j - 2;
    end
    foreach (q[j]) cmpb(SINK.qa[s + j], q[j]);
  endtask

  initial begin
    rst = 1'b1;
    pram_we = 1'b0;
    pram_addr = 9'h000;
    pram_wdata = 12'h000;
    in_y = 8'h10;
    in_c = 8'h80;
    in_active = 1'b0;
    in_href = 1'b0;
    in_vref = 1'b0;
    in_field = 1'b0;
    in_vblank = 1'b0;
    vbi = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    // Reset values, then write and read back; the last is unmapped.
    foreach (addrs[j]) begin
      rd(addrs[j], w);
      cmpw(w, rstv[j]);
      d = 12'($random(seed));
      wr(addrs[j], d);
      rd(addrs[j], w);
      cmpw(w, (j < 8) ? d : 12'h000);
    end
    // Separate-sync mode: unity gain, gain 1.5 with swap, then shuffled.
    wr(A_MUX, 12'h000);
    for (k = 0; k < 3; k++) begin
      wr(A_FMT, (k == 2) ? 12'h040 : 12'h000);
      wr(A_ADJA1, ca[k[0]]);
      wr(A_ADJB1, cb[k[0]]);
      wr(A_PEAK1, k ? 12'h100 : 12'h000);
      line(ca[k[0]], cb[k[0]], k != 0);
      chk16(k == 2);
    end
    // Embedded headers: an active line, then a blanked line.
    wr(A_ADJA1, RST_ADJA);
    wr(A_ADJB1, RST_ADJB);
    wr(A_PEAK1, 12'h000);
    wr(A_MUX, 12'h2a5);
    wr(A_FMT, 12'h001);
    for (k = 0; k < 2; k++) begin
      in_field = k[0];
      in_vblank = k[0];
      in_vref = k[0];
      line(RST_ADJA, RST_ADJB, 1'b0);
      chk656(1'b1, k[0], k[0], 1'b0);
      cmpb(pb, 8'ha5);
      cmpw({10'h000, vf}, {10'h000, k[0], k[0]});
      if (k == 1) cmpw(12'(SINK.nqual), 12'h000);
    end
    // A VBI line sent as ancillary data, limited, with the task bit low.
    vbi = 1'b1;
    wr(A_FMT, 12'h805);
    line(RST_ADJA, RST_ADJB, 1'b0);
    chk656(1'b0, 1'b1, 1'b0, 1'b1);
    vbi = 1'b0;
    // Header drop: the third blanked line keeps its pair, later ones not.
    wr(A_FMT, 12'h201);
    for (int n = 0; n < 5; n++) begin
      line(RST_ADJA, RST_ADJB, 1'b0);
      k = 0;
      foreach (SINK.qa[j]) k += (SINK.qa[j] === 8'hff) ? 1 : 0;
      cmpw(12'(k), (n == 0) ? 12'h002 : 12'h000);
    end
    finish_test;
  end
endmodule
